// [rtl/general_digital_io_port.sv]
// General digital I/O port with direction, output/pull-up and input sample registers,
// reached as an AHB-Lite slave.
// Assumes sleep and external-interrupt enables arrive from their own controllers.
//
// Contract
// - Three registers per port: output, direction, input
// - Input register read-only; output and direction RW
// - Each pin bit changes independently of others
// - Direction one makes output, zero input
// - Output pin drives output bit, ignoring disable
// - Input with output bit one pulls up
// - Global pull-up disable kills every pull-up
// - Reset tri-states all pins, clock or not
// - Writing one to input register toggles output
// - Pin readable via synchronizer in both directions
// - Latch open when clock high, then register
// - Pin change visible after half to 1.5 periods
// - Written output reaches input register one period later
// - Deep sleep clamps digital inputs to ground
// - Enabled external interrupt overrides the clamp
// - Clamp release can set interrupt flag
// - Alternate functions leave other pins unaffected
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
module general_digital_io_port
  import gpio_port_pkg::*;
#(
  parameter int PORT_W = gpio_port_pkg::PORT_W_DEF
) (
  input  wire logic                              core_clk,
  input  wire logic                              rstn,
  input  wire logic                              hsel,
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [gpio_port_pkg::DATA_W-1:0]  hwdata,
  input  wire logic                              hready,
  output logic                                   hreadyout,
  output logic                                   hresp,
  output logic      [gpio_port_pkg::DATA_W-1:0]  hrdata,
  input  wire logic [PORT_W-1:0]                 pad_in,
  output logic      [PORT_W-1:0]                 pad_out,
  output logic      [PORT_W-1:0]                 pad_oe,
  output logic      [PORT_W-1:0]                 pullup_en,
  input  wire logic                              sleep_clamp,
  input  wire logic [PORT_W-1:0]                 ext_int_enable,
  input  wire logic [PORT_W-1:0]                 alt_input_override,
  output logic      [PORT_W-1:0]                 digital_in
);
  import gpio_port_pkg::*;

  logic [PORT_W-1:0] output_reg;
  logic [PORT_W-1:0] direction_reg;
  logic [PORT_W-1:0] input_sample_reg;
  logic              pullup_disable_reg;

  bus_phase_t        phase_reg;
  logic [11:0]       addr_reg;

  logic              addr_valid;
  logic              wr_output;
  logic              wr_direction;
  logic              wr_input;
  logic              wr_mcu;
  logic [PORT_W-1:0] wdata;
  logic [PORT_W-1:0] clamp_active;
  logic [DATA_W-1:0] rd_mux;

  if (PORT_W < 1 || PORT_W > DATA_W)
  begin : g_bad_width
    $error("general_digital_io_port: PORT_W out of range");
  end

  // Bus front end: zero wait states, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = HRESP_OKAY;
  assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_reg <= PHASE_IDLE;
      addr_reg  <= 12'h000;
    end
    else if (hready)
    begin
      if (addr_valid)
      begin
        phase_reg <= hwrite ? PHASE_WRITE : PHASE_READ;
        addr_reg  <= haddr[11:0];
      end
      else
      begin
        phase_reg <= PHASE_IDLE;
      end
    end
  end

  // Write strobes take effect at the edge that ends the data phase
  always_comb
  begin
    wr_output    = 1'b0;
    wr_direction = 1'b0;
    wr_input     = 1'b0;
    wr_mcu       = 1'b0;
    case (phase_reg)
      PHASE_WRITE:
      begin
        wr_output    = reg_hit(addr_reg, OFF_OUTPUT);
        wr_direction = reg_hit(addr_reg, OFF_DIRECTION);
        wr_input     = reg_hit(addr_reg, OFF_INPUT);
        wr_mcu       = reg_hit(addr_reg, OFF_MCU_CTRL);
      end
      PHASE_IDLE,
      PHASE_READ:
      begin
        wr_output = 1'b0;
      end
      default:
      begin
        wr_output = 1'b0;
      end
    endcase
  end

  assign wdata = hwdata[PORT_W-1:0];

  // Output latch: plain write, or toggle through the input register address
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      output_reg <= {PORT_W{OUTPUT_RST_BIT}};
    else if (wr_output)
      output_reg <= wdata;
    else if (wr_input)
      output_reg <= output_reg ^ wdata;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      direction_reg <= {PORT_W{DIR_RST_BIT}};
    else if (wr_direction)
      direction_reg <= wdata;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      pullup_disable_reg <= PUD_RST;
    else if (wr_mcu)
      pullup_disable_reg <= hwdata[PUD_BIT];
  end

  // Read mux; data comes straight from the register flops during the data phase
  always_comb
  begin
    rd_mux = {DATA_W{1'b0}};
    if (phase_reg == PHASE_READ)
    begin
      if (reg_hit(addr_reg, OFF_OUTPUT))
        rd_mux[PORT_W-1:0] = output_reg;
      else if (reg_hit(addr_reg, OFF_DIRECTION))
        rd_mux[PORT_W-1:0] = direction_reg;
      else if (reg_hit(addr_reg, OFF_INPUT))
        rd_mux[PORT_W-1:0] = input_sample_reg;
      else if (reg_hit(addr_reg, OFF_MCU_CTRL))
        rd_mux[PUD_BIT] = pullup_disable_reg;
    end
  end

  assign hrdata = rd_mux;

  // Pull-up only on an input pin whose output bit is one, and only without the global disable
  function automatic logic pin_pullup(input logic dir_bit, input logic out_bit, input logic global_pullup_disable);
    pin_pullup = !dir_bit && out_bit && !global_pullup_disable;
  endfunction

  // Pad drive per pin; the reset term keeps pins released even with the clock stopped
  for (genvar i = 0; i < PORT_W; i++)
  begin : g_pin
    assign pad_out[i]   = output_reg[i];
    assign pad_oe[i]    = direction_reg[i] & rstn;
    assign pullup_en[i] = pin_pullup(direction_reg[i], output_reg[i], pullup_disable_reg) & rstn;

    a_pin_direction: assert property (@(posedge core_clk) disable iff (!rstn)
      pad_oe[i] == direction_reg[i])
      else $error("pad enable does not follow direction bit");

    a_pin_output: assert property (@(posedge core_clk) disable iff (!rstn)
      pad_oe[i] |-> (pad_out[i] == output_reg[i]) && !pullup_en[i])
      else $error("output pin not driven from output bit");

    a_pin_pullup: assert property (@(posedge core_clk) disable iff (!rstn)
      (!direction_reg[i] && output_reg[i] && !pullup_disable_reg) |-> pullup_en[i])
      else $error("input pin with output bit set has no pull-up");

    // A clamped pin must read low whatever the pad shows
    a_pin_clamp: assert property (@(posedge core_clk) disable iff (!rstn)
      (sleep_clamp && !ext_int_enable[i] && !alt_input_override[i]) |-> !digital_in[i])
      else $error("clamped pin does not read low");
  end

  // Input clamp is per pin, so an override on one pin never touches another
  assign clamp_active = {PORT_W{sleep_clamp}} & ~ext_int_enable & ~alt_input_override;

  // Releasing the clamp lets a high pin rise here, which edge logic downstream sees
  assign digital_in = pad_in & ~clamp_active;

  io_input_sync #(
    .W (PORT_W)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .din      (digital_in),
    .dout     (input_sample_reg)
  );

  // Assertions

  a_reset_tristate: assert property (@(posedge core_clk)
    !rstn |-> (pad_oe == '0) && (pullup_en == '0))
    else $error("pins not released during reset");

  a_dir_write_lands: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_direction |=> (direction_reg == $past(wdata)) && (pad_oe == $past(wdata)))
    else $error("direction write did not reach the pads");

  a_toggle_output: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_input |=> (output_reg == ($past(output_reg) ^ $past(wdata))))
    else $error("input register write did not toggle output");

  a_input_read_only: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_input |=> $stable(direction_reg) && (input_sample_reg == $past(digital_in)))
    else $error("input register write disturbed direction or sample");

  a_pullup_off: assert property (@(posedge core_clk) disable iff (!rstn)
    (wr_mcu && hwdata[PUD_BIT]) |=> (pullup_en == '0))
    else $error("pull-ups remain after global disable");

  a_output_drive: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_output |=> (pad_out == $past(wdata)) && ((pullup_en & direction_reg) == '0))
    else $error("output pad does not follow output write");

  a_sync_latency: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) |-> (input_sample_reg == $past(digital_in)))
    else $error("input sample not one period behind pin");

  a_sleep_clamp: assert property (@(posedge core_clk) disable iff (!rstn)
    (sleep_clamp && ext_int_enable == '0 && alt_input_override == '0) [*2] |-> (input_sample_reg == '0))
    else $error("sleeping inputs not clamped low");

  a_loopback_read: assert property (@(posedge core_clk) disable iff (!rstn)
    (wr_output && (direction_reg == '1)) ##1 (!sleep_clamp && (pad_in == pad_out))
      |=> (input_sample_reg == $past(wdata, 2)))
    else $error("written value not in input sample one period later");

  a_pullup_inputs: assert property (@(posedge core_clk) disable iff (!rstn)
    (pullup_en & (direction_reg | ~output_reg)) == '0)
    else $error("pull-up on an output pin or a zero output bit");

  a_pullup_global: assert property (@(posedge core_clk) disable iff (!rstn)
    pullup_disable_reg |-> (pullup_en == '0))
    else $error("pull-up on while globally disabled");

  a_pud_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_mcu |=> (pullup_disable_reg == $past(hwdata[PUD_BIT])))
    else $error("pull-up disable write lost");

  a_clamp_override: assert property (@(posedge core_clk) disable iff (!rstn)
    ((ext_int_enable | alt_input_override) & (digital_in ^ pad_in)) == '0)
    else $error("overridden pin clamped");

  a_awake_input: assert property (@(posedge core_clk) disable iff (!rstn)
    !sleep_clamp |-> (digital_in == pad_in))
    else $error("input clamped while awake");

  a_out_isolated: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_output |=> $stable(direction_reg))
    else $error("output write changed direction");

  a_dir_isolated: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_direction |=> $stable(output_reg))
    else $error("direction write changed output");

  a_output_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !(wr_output || wr_input) |=> $stable(output_reg))
    else $error("output latch changed without a write");

  a_read_direction: assert property (@(posedge core_clk) disable iff (!rstn)
    ((phase_reg == PHASE_READ) && reg_hit(addr_reg, OFF_DIRECTION))
      |-> (hrdata[PORT_W-1:0] == direction_reg))
    else $error("direction read returns wrong data");

  a_read_input: assert property (@(posedge core_clk) disable iff (!rstn)
    ((phase_reg == PHASE_READ) && reg_hit(addr_reg, OFF_INPUT))
      |-> (hrdata[PORT_W-1:0] == input_sample_reg))
    else $error("input sample read returns wrong data");

  a_read_output: assert property (@(posedge core_clk) disable iff (!rstn)
    ((phase_reg == PHASE_READ) && reg_hit(addr_reg, OFF_OUTPUT))
      |-> (hrdata[PORT_W-1:0] == output_reg))
    else $error("output latch read returns wrong data");

  // Outside a read data phase the bus must see zeros, so stale data never leaks
  a_hrdata_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    (phase_reg != PHASE_READ) |-> (hrdata == '0))
    else $error("read data outside a read data phase");

  a_bus_response: assert property (@(posedge core_clk) disable iff (!rstn)
    hreadyout && (hresp == HRESP_OKAY))
    else $error("slave inserted wait or error");

  a_unmapped_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    ((phase_reg == PHASE_WRITE) && !(wr_output || wr_direction || wr_input || wr_mcu))
      |=> $stable(output_reg) && $stable(direction_reg) && $stable(pullup_disable_reg))
    else $error("unmapped write changed a register");

  a_reset_values: assert property (@(posedge core_clk)
    !rstn |-> (output_reg == '0) && (direction_reg == '0) && !pullup_disable_reg)
    else $error("registers not zero during reset");

endmodule // general_digital_io_port

// [rtl/gpio_port_pkg.sv]
// Shared constants for the general digital I/O port: register map, reset values,
// bus encodings and the data-phase enumeration.
// Assumes an AHB-Lite master with 32-bit data and whole-word single transfers.
package gpio_port_pkg;

  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 12;
  localparam int          PORT_W_DEF     = 8;

  localparam logic [11:0] OFF_OUTPUT     = 12'h000;
  localparam logic [11:0] OFF_DIRECTION  = 12'h004;
  localparam logic [11:0] OFF_INPUT      = 12'h008;
  localparam logic [11:0] OFF_MCU_CTRL   = 12'h00c;

  localparam int          PUD_BIT        = 0;

  localparam logic        OUTPUT_RST_BIT = 1'b0;
  localparam logic        DIR_RST_BIT    = 1'b0;
  localparam logic        INPUT_RST_BIT  = 1'b0;
  localparam logic        PUD_RST        = 1'b0;

  localparam logic [1:0]  HTRANS_IDLE    = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam logic        HRESP_OKAY     = 1'b0;

  typedef enum {
    PHASE_IDLE,
    PHASE_WRITE,
    PHASE_READ
  } bus_phase_t;

  // Word-aligned match of a bus address against a register offset
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    reg_hit = (addr[11:2] == off[11:2]);
  endfunction

endpackage

// [rtl/io_input_sync.sv]
// Two-stage pin input synchronizer: a latch open while the clock is high,
// followed by a rising-edge register.
// Assumes din is the clamped digital input; the latch is read only by the register.
module io_input_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import gpio_port_pkg::*;

  logic [W-1:0] latch_q;

  if (W < 1 || W > DATA_W)
  begin : g_bad_width
    $error("io_input_sync: width out of range");
  end

  // The latch is open in the high phase and closes on the falling edge, so what it
  // holds is its input at that edge; capturing it there keeps the rising-edge
  // register from racing a transparent latch in the same time step
  always_ff @(negedge core_clk or negedge rstn)
  begin
    if (!rstn)
      latch_q <= {W{INPUT_RST_BIT}};
    else
      latch_q <= din;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      dout <= {W{INPUT_RST_BIT}};
    else
      dout <= latch_q;
  end

endmodule // io_input_sync

// [tb/general_digital_io_port_bench.sv]
// Self-checking bench for the general digital I/O port.
// Assumes one AHB-Lite master and pin_level_model on the pads.
module general_digital_io_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import gpio_port_pkg::*;
  typedef struct packed {logic [7:0] dir, out; logic global_pullup_disable; logic [7:0] een, eval, pu, smp;} row_t;
  row_t rows [5] = '{'{8'h0f, 8'h33, 1'b0, 8'hc0, 8'h80, 8'h30, 8'hb3},
                     '{8'hf0, 8'h5a, 1'b1, 8'h0f, 8'h09, 8'h00, 8'h59},
                     '{8'h00, 8'hff, 1'b0, 8'h00, 8'h00, 8'hff, 8'hff},
                     '{8'hff, 8'ha5, 1'b0, 8'h00, 8'h00, 8'h00, 8'ha5},
                     '{8'h00, 8'hff, 1'b1, 8'hff, 8'h3c, 8'h00, 8'h3c}};
  logic        core_clk = 1'b0;
  logic        rstn, hsel, hwrite, hreadyout, hresp, sleep_clamp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [7:0]  pad_in, pad_out, pad_oe, pullup_en, ext_int_enable, alt_input_override, digital_in, ext_en, ext_val;
  int          err_count, samples_checked;

  general_digital_io_port dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en),
    .sleep_clamp(sleep_clamp), .ext_int_enable(ext_int_enable), .alt_input_override(alt_input_override),
    .digital_in(digital_in));
  pin_level_model pins (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_in));

  always #10 core_clk = ~core_clk;

  task summarize;
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ready and read data are taken at the rising edge that ends the phase, before it updates
  task phase_wait(output logic [31:0] r);
    int   n;
    logic rdy;
    n = 0;
    do
    begin
      @(posedge core_clk);
      r = hrdata;
      rdy = hreadyout;
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1)
    begin
      err_count++;
      summarize();
    end
  endtask

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    phase_wait(r);
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    phase_wait(r);
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    summarize();
  end

  initial
  begin
    {rstn, hsel, hwrite, sleep_clamp, haddr, hwdata} = '0;
    {ext_en, ext_val, ext_int_enable, alt_input_override} = '0;
    htrans = HTRANS_IDLE;
    hsize = HSIZE_WORD;
    err_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    xfer(1'b0, OFF_DIRECTION, 32'h0, rd);
    check("direction_reset", 32'h0, rd);
    foreach (rows[i])
    begin
      ext_en <= rows[i].een;
      ext_val <= rows[i].eval;
      xfer(1'b1, OFF_MCU_CTRL, {31'h0, rows[i].global_pullup_disable}, rd);
      xfer(1'b1, OFF_OUTPUT, {24'h0, rows[i].out}, rd);
      xfer(1'b1, OFF_DIRECTION, {24'h0, rows[i].dir}, rd);
      @(posedge core_clk);
      check("pad_oe", {24'h0, rows[i].dir}, {24'h0, pad_oe});
      check("pad_out", {24'h0, rows[i].out}, {24'h0, pad_out});
      check("pullup_en", {24'h0, rows[i].pu}, {24'h0, pullup_en});
      xfer(1'b0, OFF_INPUT, 32'h0, rd);
      check("input_sample", {24'h0, rows[i].smp}, rd);
      xfer(1'b0, OFF_OUTPUT, 32'h0, rd);
      check("output_latch", {24'h0, rows[i].out}, rd);
      xfer(1'b0, OFF_DIRECTION, 32'h0, rd);
      check("pin_direction", {24'h0, rows[i].dir}, rd);
      xfer(1'b0, OFF_MCU_CTRL, 32'h0, rd);
      check("pullup_disable", {31'h0, rows[i].global_pullup_disable}, rd);
    end
    xfer(1'b1, OFF_INPUT, 32'h0000_003c, rd);
    xfer(1'b0, OFF_OUTPUT, 32'h0, rd);
    check("toggled_latch", 32'h0000_00c3, rd);
    xfer(1'b1, 12'h010, 32'hffff_ffff, rd);
    xfer(1'b0, 12'h010, 32'h0, rd);
    check("unmapped_read", 32'h0, rd);
    check("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    sleep_clamp <= 1'b1;
    ext_val <= 8'hff;
    ext_int_enable <= 8'h01;
    alt_input_override <= 8'h02;
    @(posedge core_clk);
    @(posedge core_clk);
    check("clamped_input", 32'h0000_0003, {24'h0, digital_in});
    ext_int_enable <= 8'h00;
    alt_input_override <= 8'h00;
    repeat (3) @(posedge core_clk);
    check("clamped_all", 32'h0, {24'h0, digital_in});
    xfer(1'b0, OFF_INPUT, 32'h0, rd);
    check("clamped_sample", 32'h0, rd);
    sleep_clamp <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    check("released_input", 32'h0000_00ff, {24'h0, digital_in});
    xfer(1'b1, OFF_DIRECTION, 32'h0000_00ff, rd);
    @(posedge core_clk);
    check("driven_oe", 32'h0000_00ff, {24'h0, pad_oe});
    // No clock edge is needed: the pads let go within the step that reset arrives
    rstn <= 1'b0;
    #1 check("reset_oe", 32'h0, {24'h0, pad_oe});
    check("reset_pullup", 32'h0, {24'h0, pullup_en});
    @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    xfer(1'b0, OFF_OUTPUT, 32'h0, rd);
    check("output_reset", 32'h0, rd);
    summarize();
  end
endmodule // general_digital_io_port_bench

// [tb/pin_level_model.sv]
// External circuitry on the port pins: optional drivers and a floating net.
// Assumes the pin controls come from general_digital_io_port.
module pin_level_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] float_reg = 8'h55;
  // Undriven pins wander every cycle so no check leans on a settled unknown
  always @(posedge core_clk)
  begin
    float_reg <= ~float_reg;
  end
  always_comb
  begin
    pad_level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
                (~pad_oe & ~ext_en & (pullup_en | float_reg));
  end
endmodule // pin_level_model
